// ===== common/dsp_map.svh
`ifndef DSP_MAP_SVH
`define DSP_MAP_SVH

// ==========================================================================
// register offsets (byte addresses)
// ==========================================================================
`define DSP_ADDR_W 5
`define DSP_OFF_DIR 5'h00
`define DSP_OFF_OUT 5'h04
`define DSP_OFF_IN 5'h08
`define DSP_OFF_SCAN 5'h0c
`define DSP_OFF_SP_INDEX 5'h10
`define DSP_OFF_SP_CMP 5'h14
`define DSP_OFF_SP_ACT 5'h18

// ==========================================================================
// sizes and field positions
// ==========================================================================
`define DSP_NUM_DIO 8
`define DSP_NUM_CHAN 8
`define DSP_NUM_SP 16
`define DSP_SP_TOTAL 128
`define DSP_SP_IDX_W 7
`define DSP_CTRL_VALID_BIT 7
`define DSP_CTRL_TYPE_LSB 0
`define DSP_SCAN_IN_BIT 0
`define DSP_SCAN_OUT_BIT 1
`define DSP_OUT_DATA_LSB 0
`define DSP_OUT_MASK_LSB 8
`define DSP_CMP_A_LSB 0
`define DSP_CMP_B_LSB 16
`define DSP_ACT_DATA_LSB 0
`define DSP_ACT_MASK_LSB 8
`define DSP_ACT_CTRL_LSB 16

// ==========================================================================
// reset values
// ==========================================================================
`define DSP_RST_DIR 8'h00
`define DSP_RST_OUT 8'h00
`define DSP_RST_SCAN 2'h0
`define DSP_RST_CTRL 8'h00
`define DSP_RST_INDEX 7'h00

`endif

// ===== common/dsp_pkg.sv
package dsp_pkg;

    // ======================================================================
    // comparison types held in the control byte
    // ======================================================================
    typedef enum logic [1:0] {
        DSP_CMP_GREATER,
        DSP_CMP_LESS,
        DSP_CMP_INSIDE,
        DSP_CMP_OUTSIDE
    } dsp_cmp_e;

    typedef logic [7:0] dsp_byte_t;
    typedef logic [15:0] dsp_word_t;

endpackage : dsp_pkg

// ===== logic/dsp_compare.sv
`timescale 1ns/100ps
`include "dsp_map.svh"

// ==========================================================================
// one set-point comparator
// ==========================================================================
module dsp_compare (
    input wire logic [15:0] value,
    input wire logic [15:0] lim_a,
    input wire logic [15:0] lim_b,
    input wire logic [7:0] ctrl,
    output logic hit
);

    dsp_pkg::dsp_cmp_e kind;
    logic cond;

    // values are treated as unsigned codes; window bounds count as inside
    always_comb begin
        kind = dsp_pkg::dsp_cmp_e'(ctrl[`DSP_CTRL_TYPE_LSB +: 2]);
        case (kind)
            dsp_pkg::DSP_CMP_GREATER: cond = value > lim_a;
            dsp_pkg::DSP_CMP_LESS: cond = value < lim_a;
            dsp_pkg::DSP_CMP_INSIDE: cond = (value >= lim_a) && (value <= lim_b);
            dsp_pkg::DSP_CMP_OUTSIDE: cond = (value < lim_a) || (value > lim_b);
            default: cond = 1'b0;
        endcase
        hit = cond && ctrl[`DSP_CTRL_VALID_BIT];
    end

endmodule : dsp_compare

// ===== logic/dsp_port.sv
// Added by the designer: the address map and register access over APB.
`timescale 1ns/100ps
`include "dsp_map.svh"

// ==========================================================================
// digital i/o port with set-point driven output updates
// ==========================================================================
module dsp_port (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sample_valid,
    input wire logic [2:0] sample_chan,
    input wire logic [15:0] sample_value,
    input wire logic scan_strobe,
    output logic scan_valid,
    output logic [7:0] scan_in_data,
    output logic [7:0] scan_out_data,
    output logic scan_in_en,
    output logic scan_out_en,
    input wire logic [7:0] dio_i,
    output logic [7:0] dio_o,
    output logic [7:0] dio_oe
);

    // ======================================================================
    // declarations
    // ======================================================================
    logic [7:0] dir;
    logic [7:0] out_port;
    logic [1:0] scan_cfg;
    logic [`DSP_SP_IDX_W-1:0] sp_index;
    logic [7:0] next_dir;
    logic [7:0] next_out;
    logic [1:0] next_scan_cfg;
    logic [`DSP_SP_IDX_W-1:0] next_sp_index;
    logic [31:0] next_prdata;
    logic next_scan_valid;
    logic [7:0] next_scan_in;
    logic [7:0] next_scan_out;
    logic [7:0] next_oe;
    logic [7:0] pin_meta;
    logic [7:0] pin_sync;
    logic [15:0] cmp_a [`DSP_SP_TOTAL];
    logic [15:0] cmp_b [`DSP_SP_TOTAL];
    logic [7:0] act_data [`DSP_SP_TOTAL];
    logic [7:0] act_mask [`DSP_SP_TOTAL];
    logic [7:0] act_ctrl [`DSP_SP_TOTAL];
    logic [`DSP_NUM_SP-1:0] sp_hit;
    logic [7:0] sel_data [`DSP_NUM_SP];
    logic [7:0] sel_mask [`DSP_NUM_SP];
    logic [`DSP_ADDR_W-1:0] reg_addr;
    logic addr_ok;
    logic access;
    logic wr_en;
    logic setup;
    logic [7:0] upd_data;
    logic [7:0] upd_mask;

    // ======================================================================
    // apb decode
    // ======================================================================
    // zero wait states: the read word is captured in the setup cycle
    // with clk_en low pready stays low, so a freeze in the access phase stretches it; a read frozen in its setup cycle returns the old read word
    assign reg_addr = paddr[`DSP_ADDR_W-1:0];
    assign access = psel && penable && clk_en;
    assign setup = psel && !penable && clk_en;
    assign wr_en = access && pwrite && addr_ok;
    assign pready = access;
    assign pslverr = access && !addr_ok;

    // an output write carries its update byte low and the mask for it one byte up
    assign upd_data = pwdata[`DSP_OUT_DATA_LSB +: 8];
    assign upd_mask = pwdata[`DSP_OUT_MASK_LSB +: 8];

    // only the seven word offsets are mapped; anything else errors
    always_comb begin
        addr_ok = (paddr[31:`DSP_ADDR_W] == 27'h0000000);
        case (reg_addr)
            `DSP_OFF_DIR, `DSP_OFF_OUT, `DSP_OFF_IN, `DSP_OFF_SCAN,
            `DSP_OFF_SP_INDEX, `DSP_OFF_SP_CMP, `DSP_OFF_SP_ACT: begin
            end
            default: addr_ok = 1'b0;
        endcase
    end

    // ======================================================================
    // pin input synchroniser
    // ======================================================================
    // terminals are asynchronous; two stages before anything reads them
    // only the second stage is read, so a metastable first stage never spreads
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pin_meta <= 8'h00;
            pin_sync <= 8'h00;
        end else if (clk_en) begin
            pin_meta <= dio_i;
            pin_sync <= pin_meta;
        end
    end

    // ======================================================================
    // set-point table
    // ======================================================================
    // one slice per entry: only the entry picked by the index register takes a write,
    // and that may happen at any time, also while samples stream in
    generate
        for (genvar e = 0; e < `DSP_SP_TOTAL; e++) begin : gen_entry
            localparam logic [6:0] ENTRY = 7'(e);
            logic sel_cmp;
            logic sel_act;
            logic [15:0] next_cmp_a;
            logic [15:0] next_cmp_b;
            logic [7:0] next_act_data;
            logic [7:0] next_act_mask;
            logic [7:0] next_act_ctrl;

            assign sel_cmp = wr_en && (reg_addr == `DSP_OFF_SP_CMP) && (sp_index == ENTRY);
            assign sel_act = wr_en && (reg_addr == `DSP_OFF_SP_ACT) && (sp_index == ENTRY);

            // next words of this entry
            always_comb begin
                next_cmp_a = cmp_a[e];
                next_cmp_b = cmp_b[e];
                next_act_data = act_data[e];
                next_act_mask = act_mask[e];
                next_act_ctrl = act_ctrl[e];
                if (sel_cmp) begin
                    next_cmp_a = pwdata[`DSP_CMP_A_LSB +: 16];
                    next_cmp_b = pwdata[`DSP_CMP_B_LSB +: 16];
                end
                if (sel_act) begin
                    next_act_data = pwdata[`DSP_ACT_DATA_LSB +: 8];
                    next_act_mask = pwdata[`DSP_ACT_MASK_LSB +: 8];
                    next_act_ctrl = pwdata[`DSP_ACT_CTRL_LSB +: 8];
                end
            end

            // limits, data and mask carry no reset: the cleared control byte keeps the
            // entry off, so those words are never used before software has set them
            always_ff @(posedge sys_clk) begin
                if (clk_en) begin
                    cmp_a[e] <= next_cmp_a;
                    cmp_b[e] <= next_cmp_b;
                    act_data[e] <= next_act_data;
                    act_mask[e] <= next_act_mask;
                end
            end

            // control bytes clear on reset so no entry fires on stale contents
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    act_ctrl[e] <= `DSP_RST_CTRL;
                end else if (clk_en) begin
                    act_ctrl[e] <= next_act_ctrl;
                end
            end
        end
    endgenerate

    // ======================================================================
    // comparators for the sampled channel
    // ======================================================================
    // all sixteen entries of the arriving channel are judged in parallel
    generate
        for (genvar g = 0; g < `DSP_NUM_SP; g++) begin : gen_sp
            localparam logic [3:0] SLOT = 4'(g);
            logic [`DSP_SP_IDX_W-1:0] idx;
            assign idx = {sample_chan, SLOT};
            assign sel_data[g] = act_data[idx];
            assign sel_mask[g] = act_mask[idx];
            dsp_compare u_cmp (
                .value(sample_value),
                .lim_a(cmp_a[idx]),
                .lim_b(cmp_b[idx]),
                .ctrl(act_ctrl[idx]),
                .hit(sp_hit[g])
            );
        end
    endgenerate

    // ======================================================================
    // output port next value
    // ======================================================================
    // set-point hits go in ascending order, then a software write lands last
    // letting software win keeps a direct write from being lost to a same-cycle hit
    always_comb begin
        next_out = out_port;
        if (sample_valid) begin
            for (int i = 0; i < `DSP_NUM_SP; i++) begin
                if (sp_hit[i]) begin
                    next_out = (next_out & ~sel_mask[i]) | (sel_data[i] & sel_mask[i]);
                end
            end
        end
        if (wr_en && (reg_addr == `DSP_OFF_OUT)) begin
            next_out = (next_out & ~upd_mask) | (upd_data & upd_mask);
        end
    end

    // ======================================================================
    // configuration next values
    // ======================================================================
    // direction, scan and index registers take a write at any time
    always_comb begin
        next_dir = dir;
        next_scan_cfg = scan_cfg;
        next_sp_index = sp_index;
        if (wr_en) begin
            case (reg_addr)
                `DSP_OFF_DIR: next_dir = pwdata[7:0];
                `DSP_OFF_SCAN: next_scan_cfg = pwdata[1:0];
                `DSP_OFF_SP_INDEX: next_sp_index = pwdata[`DSP_SP_IDX_W-1:0];
                default: begin
                end
            endcase
        end
        // a set bit in the output latch sinks the pin only when the channel is an output
        next_oe = next_dir & next_out;
    end

    // ======================================================================
    // read data next value
    // ======================================================================
    // read data is loaded in the setup cycle and stands until the next setup;
    // reads have no side effects; a refused read returns zero below 0x20, above that the low five bits alias a register
    always_comb begin
        next_prdata = prdata;
        if (setup) begin
            next_prdata = 32'h00000000;
            case (reg_addr)
                `DSP_OFF_DIR: next_prdata[7:0] = dir;
                `DSP_OFF_OUT: next_prdata[7:0] = out_port;
                `DSP_OFF_IN: next_prdata[7:0] = pin_sync;
                `DSP_OFF_SCAN: next_prdata[1:0] = scan_cfg;
                `DSP_OFF_SP_INDEX: next_prdata[`DSP_SP_IDX_W-1:0] = sp_index;
                `DSP_OFF_SP_CMP: next_prdata = {cmp_b[sp_index], cmp_a[sp_index]};
                `DSP_OFF_SP_ACT: begin
                    next_prdata[23:0] = {act_ctrl[sp_index], act_mask[sp_index],
                        act_data[sp_index]};
                end
                default: next_prdata = 32'h00000000;
            endcase
        end
    end

    // ======================================================================
    // scan group entry next values
    // ======================================================================
    // the strobe marks one scan slot; both bytes are captured together
    always_comb begin
        next_scan_valid = scan_strobe;
        next_scan_in = scan_in_data;
        next_scan_out = scan_out_data;
        if (scan_strobe) begin
            next_scan_in = pin_sync;
            next_scan_out = out_port;
        end
    end

    // ======================================================================
    // state registers
    // ======================================================================
    // a low clock enable holds every register, outputs included
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            dir <= `DSP_RST_DIR;
            out_port <= `DSP_RST_OUT;
            scan_cfg <= `DSP_RST_SCAN;
            sp_index <= `DSP_RST_INDEX;
            prdata <= 32'h00000000;
            dio_oe <= 8'h00;
            scan_valid <= 1'b0;
            scan_in_data <= 8'h00;
            scan_out_data <= 8'h00;
        end else if (clk_en) begin
            dir <= next_dir;
            out_port <= next_out;
            scan_cfg <= next_scan_cfg;
            sp_index <= next_sp_index;
            prdata <= next_prdata;
            dio_oe <= next_oe;
            scan_valid <= next_scan_valid;
            scan_in_data <= next_scan_in;
            scan_out_data <= next_scan_out;
        end
    end

    // ======================================================================
    // pin and scan enable outputs
    // ======================================================================
    // open-drain: the driven level is always low, only the enable moves
    assign dio_o = 8'h00;
    assign scan_in_en = scan_cfg[`DSP_SCAN_IN_BIT];
    assign scan_out_en = scan_cfg[`DSP_SCAN_OUT_BIT];

endmodule : dsp_port

// ===== tb/dsp_port_monitor.sv
`timescale 1ns/100ps
// ======================================================================
// port-level checker for the digital i/o port
module dsp_port_monitor (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic sample_valid,
    input wire logic scan_strobe,
    input wire logic scan_valid,
    input wire logic [7:0] dio_o,
    input wire logic [7:0] dio_oe
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    logic acc;
    logic wr_out;
    // direct output writes with no competing sample in the same cycle
    assign acc = psel && penable && clk_en;
    assign wr_out = acc && pwrite && paddr == 32'h4 && !sample_valid;
    a_sink_only: assert property (dio_o == 8'h0)
        else $error("pin driver not at sink level");
    a_ready_zero: assert property (pready == acc)
        else $error("pready not zero-wait");
    a_slverr_map: assert property (acc |->
        pslverr == (paddr > 32'h18 || paddr[1:0] != 2'h0))
        else $error("pslverr does not match address map");
    a_scan_pulse: assert property (scan_strobe && clk_en |=> scan_valid)
        else $error("scan entry missing after strobe");
    a_scan_origin: assert property ($rose(scan_valid) |-> $past(scan_strobe))
        else $error("scan entry without strobe");
    a_out_clear: assert property (wr_out |=>
        (dio_oe & $past(pwdata[15:8]) & ~$past(pwdata[7:0])) == 8'h0)
        else $error("masked-in zero bit still sinking");
    a_out_keep: assert property (wr_out |=>
        ((dio_oe ^ $past(dio_oe)) & ~$past(pwdata[15:8])) == 8'h0)
        else $error("masked-out bit changed");
    a_oe_cause: assert property ($changed(dio_oe) |->
        $past(sample_valid || acc && pwrite))
        else $error("outputs changed with no write or sample");
endmodule : dsp_port_monitor

bind dsp_port dsp_port_monitor i_dsp_port_monitor (.sys_clk(sys_clk), .rst(rst),
    .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .sample_valid(sample_valid),
    .scan_strobe(scan_strobe), .scan_valid(scan_valid), .dio_o(dio_o), .dio_oe(dio_oe));

// ===== tb/dsp_terminal.sv
`timescale 1ns/100ps
// ======================================================================
// terminal side: pull-ups plus outside drivers
module dsp_terminal (
    input wire logic [7:0] dio_oe,
    input wire logic [7:0] drv_en,
    input wire logic [7:0] drv_val,
    output logic [7:0] pin
);
    // wired-and: a sinking transistor beats any driver, free lines float high
    assign pin = ~dio_oe & (drv_val | ~drv_en);
endmodule : dsp_terminal

// ===== tb/dsp_port_tb.sv
`timescale 1ns/100ps
// ======================================================================
// bench for the digital i/o port
module dsp_port_tb;
    logic sys_clk, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, pready, pslverr;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rdata;
    logic sample_valid = 1'h0, scan_strobe = 1'h0, scan_valid, scan_in_en, scan_out_en;
    logic [2:0] sample_chan = 3'h0;
    logic [15:0] sample_value = 16'h0;
    logic [7:0] scan_in_data, scan_out_data, dio_i, dio_o, dio_oe;
    logic [7:0] drv_en = 8'h0, drv_val = 8'h0;
    logic err, clk_en = 1'h1;
    int failures = 0, checks_done = 0, cycles = 0;
    // hit and miss samples per comparison type, limits 100 and 200
    logic [15:0] hit_v [4] = '{16'h65, 16'h63, 16'h64, 16'hc9};
    logic [15:0] miss_v [4] = '{16'h64, 16'h64, 16'hc9, 16'hc8};

    dsp_port i_dsp_port (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .sample_valid(sample_valid),
        .sample_chan(sample_chan), .sample_value(sample_value), .scan_strobe(scan_strobe),
        .scan_valid(scan_valid), .scan_in_data(scan_in_data), .scan_out_data(scan_out_data),
        .scan_in_en(scan_in_en), .scan_out_en(scan_out_en), .dio_i(dio_i), .dio_o(dio_o),
        .dio_oe(dio_oe));
    dsp_terminal i_dsp_terminal (.dio_oe(dio_oe), .drv_en(drv_en), .drv_val(drv_val),
        .pin(dio_i));

    initial begin
        sys_clk = 1'h0;
        forever #4 sys_clk = ~sys_clk;
    end

    // hang guard: the whole run needs well under a thousand cycles
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            failures++;
            final_report();
        end
    end

    task automatic final_report;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : final_report

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // one apb transfer; request held until pready is seen at an edge
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'h1;
        do @(posedge sys_clk); while (pready !== 1'h1);
        rdata = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        apb(1'h1, a, d);
    endtask : wr

    task automatic rdc(input logic [31:0] a, input logic [31:0] e);
        apb(1'h0, a, 32'h0);
        chk(rdata, e);
    endtask : rdc

    task automatic oechk(input logic [7:0] e);
        @(negedge sys_clk);
        chk(dio_oe, e);
    endtask : oechk

    task automatic sp(input logic [6:0] i, input logic [31:0] lim, input logic [23:0] act);
        wr(32'h10, {25'h0, i});
        wr(32'h14, lim);
        wr(32'h18, {8'h0, act});
    endtask : sp

    task automatic samp(input logic [2:0] c, input logic [15:0] v);
        @(posedge sys_clk);
        sample_valid <= 1'h1;
        sample_chan <= c;
        sample_value <= v;
        @(posedge sys_clk);
        sample_valid <= 1'h0;
    endtask : samp

    initial begin
        repeat (6) @(posedge sys_clk);
        rst <= 1'h0;
        rdc(32'h0, 32'h0);
        rdc(32'h4, 32'h0);
        rdc(32'hc, 32'h0);
        // all outputs, full mask: pins sink at once
        wr(32'h0, 32'hff);
        wr(32'h4, 32'hffa5);
        oechk(8'ha5);
        repeat (3) @(posedge sys_clk);
        rdc(32'h8, 32'h5a);
        wr(32'h4, 32'h0f00);
        rdc(32'h4, 32'ha0);
        // low nibble input: transistor off, outside driver sets the level
        wr(32'h0, 32'hf0);
        wr(32'h4, 32'hffff);
        oechk(8'hf0);
        drv_en <= 8'h0f;
        drv_val <= 8'h06;
        repeat (3) @(posedge sys_clk);
        rdc(32'h8, 32'h06);
        wr(32'hc, 32'h3);
        @(negedge sys_clk);
        chk({scan_out_en, scan_in_en}, 2'h3);
        @(posedge sys_clk);
        scan_strobe <= 1'h1;
        @(posedge sys_clk);
        scan_strobe <= 1'h0;
        @(negedge sys_clk);
        chk(scan_valid, 1'h1);
        chk(scan_in_data, 8'h06);
        chk(scan_out_data, 8'hff);
        @(negedge sys_clk);
        chk(scan_valid, 1'h0);
        // every comparison type on channel 3 slot 0, window bounds inclusive
        wr(32'h0, 32'hff);
        for (int t = 0; t < 4; t++) begin
            sp(7'h30, 32'h00c80064, {6'h20, t[1:0], 8'hff, 8'h10 + t[7:0]});
            wr(32'h4, 32'hff00);
            samp(3'h3, miss_v[t]);
            rdc(32'h4, 32'h0);
            samp(3'h3, hit_v[t]);
            rdc(32'h4, 32'h10 + t);
        end
        // two hits in one sample: higher slot applied last
        sp(7'h35, 32'h0, 24'h800f0c);
        wr(32'h4, 32'hff00);
        samp(3'h3, 16'h12c);
        rdc(32'h4, 32'h1c);
        // last slot of last channel, disabled then enabled
        sp(7'h7f, 32'h32, 24'h018080);
        samp(3'h7, 16'ha);
        rdc(32'h4, 32'h1c);
        sp(7'h7f, 32'h32, 24'h818080);
        samp(3'h7, 16'ha);
        rdc(32'h4, 32'h9c);
        // unmapped and misaligned places are refused and ignored
        rdc(32'h1c, 32'h0);
        chk(err, 1'h1);
        wr(32'h5, 32'hff00);
        rdc(32'h4, 32'h9c);
        // clock enable low: a hitting sample is ignored, then taken once running again
        wr(32'h4, 32'hff00);
        clk_en <= 1'h0;
        samp(3'h7, 16'ha);
        clk_en <= 1'h1;
        rdc(32'h4, 32'h0);
        samp(3'h7, 16'ha);
        rdc(32'h4, 32'h80);
        final_report();
    end
endmodule : dsp_port_tb
